// ===== rtl/siexec_pkg.sv
// Constants, encodings and reset values for the skip-increment and table-read execution unit
package siexec_pkg;
  localparam logic [5:0]  SIE_OP_INCSZ   = 6'h0f;   // 0011 11
  localparam logic [5:0]  SIE_OP_INSNZ   = 6'h12;   // 0100 10
  localparam logic [13:0] SIE_OP_TABLE_READ_OP   = 14'h0002; // 0000 0000 0000 10 followed by mode
  localparam logic [15:0] SIE_OP_SLEEP   = 16'h0003;
  localparam logic [1:0]  SIE_TM_NONE    = 2'h0;
  localparam logic [1:0]  SIE_TM_POSTINC = 2'h1;
  localparam logic [1:0]  SIE_TM_POSTDEC = 2'h2;
  localparam logic [1:0]  SIE_TM_PREINC  = 2'h3;
  localparam logic [7:0]  SIE_IDX_LIMIT  = 8'h5f;
  localparam int          SIE_TP_W       = 21;
  localparam logic [SIE_TP_W-1:0] SIE_TP_RST = 21'h000000;
  localparam logic [7:0]  SIE_BYTE_RST   = 8'h00;
  localparam logic [1:0]  SIE_Q_LAST     = 2'h3;     // Four quarter cycles per instruction cycle
  typedef enum logic [2:0] {SIE_EXEC, SIE_NOP1, SIE_NOP2, SIE_TBL2, SIE_SLEEPING} siexec_state_t;
endpackage

// ===== rtl/siexec_incr.sv
// Incrementer, skip decision and data address formation for byte-oriented ops
`timescale 1ns/1ps
`default_nettype none
module siexec_incr
  import siexec_pkg::*;
(
  input  wire logic       is_incsz_i,
  input  wire logic [7:0] operand_i,
  input  wire logic       acc_bit_i,
  input  wire logic       ext_en_i,
  input  wire logic [7:0] faddr_i,
  input  wire logic [3:0] bank_select_reg_i,
  input  wire logic [7:0] fsr2_i,
  output logic [7:0]      result_o,
  output logic            skip_o,
  output logic [11:0]     daddr_o,
  output logic            indexed_o
);
  // Sum and skip condition, sense chosen by opcode
  assign result_o  = operand_i + 8'h01;
  assign skip_o    = is_incsz_i ? (result_o == 8'h00) : (result_o != 8'h00);
  // Bank and addressing mode selection
  assign indexed_o = !acc_bit_i && ext_en_i && (faddr_i <= SIE_IDX_LIMIT);
  assign daddr_o   = indexed_o ? {4'h0, fsr2_i + faddr_i} :
                     acc_bit_i ? {bank_select_reg_i, faddr_i} :
                     (faddr_i[7] ? {4'hf, faddr_i} : {4'h0, faddr_i});
endmodule
`default_nettype wire

// ===== rtl/siexec_core.sv
// Execution sequencer for increment-skip, table read and low-power entry ops
`timescale 1ns/1ps
`default_nettype none
module siexec_core
  import siexec_pkg::*;
(
  input  wire logic                sys_clk_i,
  input  wire logic                rst_b_i,
  input  wire logic                instr_valid_i,   // Instruction word at Q1 of a cycle
  input  wire logic [15:0]         instr_i,
  input  wire logic                next_two_word_i, // Prefetched next is a two-word op
  input  wire logic                ext_en_i,
  input  wire logic [3:0]          bank_select_reg_i,
  input  wire logic [7:0]          fsr2_i,
  input  wire logic [7:0]          file_rdata_i,
  input  wire logic [7:0]          pmem_rdata_i,
  output logic [1:0]               qphase_o,
  output logic                     busy_o,
  output logic [11:0]              file_addr_o,
  output logic                     file_we_o,
  output logic [7:0]               file_wdata_o,
  output logic                     w_we_o,
  output logic [7:0]               w_wdata_o,
  output logic                     flush_o,
  output logic                     pmem_re_o,
  output logic [SIE_TP_W-1:0]      table_pointer_o,
  output logic [7:0]               table_latch_o,
  output logic                     watchdog_clr_o,
  output logic                     timeout_flag_o,
  output logic                     powerdown_flag_o,
  output logic                     osc_stop_o
);
  siexec_state_t state_reg, state_next;
  logic [1:0]          q_reg;
  logic [15:0]         ir_reg;
  logic [SIE_TP_W-1:0] tp_reg, tp_next;
  logic [7:0]          tl_reg, tl_next;
  logic [11:0]         fa_reg;
  logic                fwe_reg, wwe_reg, fl_reg, pre_reg, wdc_reg, to_reg, pd_reg, osc_reg;
  logic [7:0]          fwd_reg, wwd_reg;
  logic                extra_reg;
  logic                act_reg;   // An instruction was taken and is in its execute cycle
  logic                busy_reg;  // Registered copy of the not-executing state

  ////////////////////////////////////////////////////////////////////////////////
  // Timing of one instruction cycle
  // The word is taken at the edge where the quarter counter reads 0 and is held
  // in the instruction register from then on. The file address is formed from
  // the live word at that same edge, so the memory side has three quarters to
  // return the operand. All execute decisions at the last quarter use the held
  // word, never the live bus: the live word may already have moved on, and a
  // decode of the live bus at quarter 3 need not see the taken instruction.
  // Write-back, flush and the table read strobe are registered at the last
  // quarter and stand for exactly one clock at the start of the next cycle.
  // Busy is registered from the next state so that it rises with the state
  // and stays glitch free at the port.

  ////////////////////////////////////////////////////////////////////////////////
  // Decode
  wire       q_end     = (q_reg == SIE_Q_LAST);
  wire       take      = (state_reg == SIE_EXEC) && instr_valid_i && (q_reg == 2'h0);
  // Execute-time decode works on the held instruction word
  wire       is_incsz  = (ir_reg[15:10] == SIE_OP_INCSZ);
  wire       is_insnz  = (ir_reg[15:10] == SIE_OP_INSNZ);
  wire       is_incr   = is_incsz || is_insnz;
  wire       is_tbl    = (ir_reg[15:2] == SIE_OP_TABLE_READ_OP);
  wire       is_sleep  = (ir_reg == SIE_OP_SLEEP);
  wire [1:0] tmode     = ir_reg[1:0];
  wire       dest_file = ir_reg[9];
  wire [7:0] inc_res;
  wire       skip;
  wire [11:0] daddr;

  siexec_incr u_incr (
    .is_incsz_i        (is_incsz),
    .operand_i         (file_rdata_i),
    .acc_bit_i         (instr_i[8]),
    .ext_en_i          (ext_en_i),
    .faddr_i           (instr_i[7:0]),
    .bank_select_reg_i (bank_select_reg_i),
    .fsr2_i            (fsr2_i),
    .result_o          (inc_res),
    .skip_o            (skip),
    .daddr_o           (daddr),
    .indexed_o         ()
  );

  // Table pointer update; pre-increment moves before the read, post-increment and post-decrement after
  wire [SIE_TP_W-1:0] tp_inc = tp_reg + 21'h000001;
  wire [SIE_TP_W-1:0] tp_dec = tp_reg - 21'h000001;

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic, evaluated at the last quarter of a cycle
  always_comb begin
    state_next = state_reg;
    tp_next    = tp_reg;
    tl_next    = tl_reg;
    if (q_end) begin
      case (state_reg)
        SIE_EXEC: begin
          if (act_reg && is_tbl) begin
            state_next = SIE_TBL2;
            if (tmode == SIE_TM_PREINC) begin
              tp_next = tp_inc;
            end
          end else if (act_reg && is_incr && skip) begin
            state_next = SIE_NOP1;
          end else if (act_reg && is_sleep) begin
            state_next = SIE_SLEEPING;
          end
        end
        SIE_NOP1: begin
          state_next = extra_reg ? SIE_NOP2 : SIE_EXEC;
        end
        SIE_NOP2: begin
          state_next = SIE_EXEC;
        end
        SIE_TBL2: begin
          tl_next    = pmem_rdata_i;
          state_next = SIE_EXEC;
          case (ir_reg[1:0])
            SIE_TM_POSTINC: tp_next = tp_inc;
            SIE_TM_POSTDEC: tp_next = tp_dec;
            default:        tp_next = tp_reg;
          endcase
        end
        SIE_SLEEPING: begin
          state_next = SIE_SLEEPING;                                      // Left only by reset
        end
        default: begin
          state_next = SIE_EXEC;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer registers
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      state_reg <= SIE_EXEC;
      q_reg     <= 2'h0;
      ir_reg    <= 16'h0000;
      tp_reg    <= SIE_TP_RST;
      tl_reg    <= SIE_BYTE_RST;
      extra_reg <= 1'b0;
      act_reg   <= 1'b0;
      busy_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      busy_reg  <= (state_next != SIE_EXEC);
      // Execute flag lives from the take edge to the last quarter
      if (take) begin
        act_reg <= 1'b1;
      end else if (q_end) begin
        act_reg <= 1'b0;
      end
      q_reg     <= q_reg + 2'h1;
      tp_reg    <= tp_next;
      tl_reg    <= tl_next;
      if (take) begin
        ir_reg    <= instr_i;
        extra_reg <= next_two_word_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write-back and side effects; all pulses last one clock at Q1 of the next cycle
  wire wb       = act_reg && is_incr && q_end;
  wire sleep_go = act_reg && is_sleep && q_end;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      fa_reg  <= 12'h000;
      fwe_reg <= 1'b0;
      fwd_reg <= SIE_BYTE_RST;
      wwe_reg <= 1'b0;
      wwd_reg <= SIE_BYTE_RST;
      fl_reg  <= 1'b0;
      pre_reg <= 1'b0;
      wdc_reg <= 1'b0;
      to_reg  <= 1'b1;
      pd_reg  <= 1'b1;
      osc_reg <= 1'b0;
    end else begin
      if (take) begin
        fa_reg <= daddr;
      end
      fwe_reg <= wb && dest_file;
      wwe_reg <= wb && !dest_file;
      fwd_reg <= inc_res;
      wwd_reg <= inc_res;
      fl_reg  <= wb && skip;
      pre_reg <= (state_next == SIE_TBL2) && q_end;
      wdc_reg <= sleep_go;
      if (sleep_go) begin
        to_reg  <= 1'b1;
        pd_reg  <= 1'b0;
        osc_reg <= 1'b1;
      end
    end
  end

  // Output drive straight from flip-flops
  assign qphase_o         = q_reg;
  assign busy_o           = busy_reg;
  assign file_addr_o      = fa_reg;
  assign file_we_o        = fwe_reg;
  assign file_wdata_o     = fwd_reg;
  assign w_we_o           = wwe_reg;
  assign w_wdata_o        = wwd_reg;
  assign flush_o          = fl_reg;
  assign pmem_re_o        = pre_reg;
  assign table_pointer_o  = tp_reg;
  assign table_latch_o    = tl_reg;
  assign watchdog_clr_o   = wdc_reg;
  assign timeout_flag_o   = to_reg;
  assign powerdown_flag_o = pd_reg;
  assign osc_stop_o       = osc_reg;
endmodule
`default_nettype wire

// ===== tb/siexec_properties.sv
// Concurrent checks on the ports of the execution sequencer
`timescale 1ns/1ps
`default_nettype none
module siexec_properties
  import siexec_pkg::*;
(
  input wire logic                sys_clk_i,
  input wire logic                rst_b_i,
  input wire logic                instr_valid_i,
  input wire logic [15:0]         instr_i,
  input wire logic                next_two_word_i,
  input wire logic [7:0]          file_rdata_i,
  input wire logic [7:0]          pmem_rdata_i,
  input wire logic [1:0]          qphase_o,
  input wire logic                busy_o,
  input wire logic                file_we_o,
  input wire logic [7:0]          file_wdata_o,
  input wire logic                w_we_o,
  input wire logic [7:0]          w_wdata_o,
  input wire logic                flush_o,
  input wire logic                pmem_re_o,
  input wire logic [SIE_TP_W-1:0] table_pointer_o,
  input wire logic [7:0]          table_latch_o,
  input wire logic                watchdog_clr_o,
  input wire logic                timeout_flag_o,
  input wire logic                powerdown_flag_o,
  input wire logic                osc_stop_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Instruction acceptance and opcode classes
  wire take  = qphase_o == 2'h0 && !busy_o && instr_valid_i;
  wire is_sz = instr_i[15:10] == SIE_OP_INCSZ;
  wire incr  = is_sz || instr_i[15:10] == SIE_OP_INSNZ;
  wire tbl   = instr_i[15:2] == SIE_OP_TABLE_READ_OP;
  ////////////////////////////////////////////////////////////////////////////////
  property p_skip; take && incr |-> ##4 flush_o == (($past(file_rdata_i) == 8'hff) == $past(is_sz, 4)); endproperty
  a_skip: assert property (p_skip) else $error("skip decision wrong");
  property p_dest; take && incr |-> ##4 file_we_o == $past(instr_i[9], 4) && w_we_o != file_we_o; endproperty
  a_dest: assert property (p_dest) else $error("wrong destination");
  property p_wdat;
    take && incr |-> ##4 (file_we_o ? file_wdata_o : w_wdata_o) == $past(file_rdata_i) + 8'h1;
  endproperty
  a_wdat: assert property (p_wdat) else $error("increment result wrong");
  property p_nop; flush_o |-> busy_o [*4]; endproperty
  a_nop: assert property (p_nop) else $error("skip cycle too short");
  property p_two; flush_o && $past(next_two_word_i, 4) |-> busy_o [*8]; endproperty
  a_two: assert property (p_two) else $error("two-word skip too short");
  property p_tre; take && tbl |-> ##4 pmem_re_o && busy_o; endproperty
  a_tre: assert property (p_tre) else $error("table read cycle missing");
  property p_lat; take && tbl |-> ##8 table_latch_o == $past(pmem_rdata_i); endproperty
  a_lat: assert property (p_lat) else $error("latch not loaded");
  property p_ptr;
    take && tbl && instr_i[1:0] == SIE_TM_POSTINC |-> ##8 table_pointer_o == $past(table_pointer_o, 8) + 1'b1;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer not incremented");
  property p_slp;
    take && instr_i == SIE_OP_SLEEP |-> ##4 watchdog_clr_o && osc_stop_o && timeout_flag_o && !powerdown_flag_o;
  endproperty
  a_slp: assert property (p_slp) else $error("low-power entry wrong");
endmodule
`default_nettype wire

// ===== tb/siexec_core_test.sv
// Self-checking testbench for the skip-increment and table-read execution unit
`timescale 1ns/1ps
`default_nettype none
module siexec_core_test;
  import siexec_pkg::*;
  logic                clk, rst_b, vld, two, ext, busy, fwe, wwe, flush, pre, wclr, tof, pdf, ostop;
  logic [15:0]         instr;
  logic [11:0]         fadr;
  logic [7:0]          fsr2, frd, pmd, fwd, wwd, lat;
  logic [3:0]          bank_select_reg;
  logic [1:0]          q;
  logic [SIE_TP_W-1:0] tp;
  int                  error_cnt, cmp_count;
  siexec_core dut (.sys_clk_i(clk), .rst_b_i(rst_b), .instr_valid_i(vld), .instr_i(instr),
    .next_two_word_i(two), .ext_en_i(ext), .bank_select_reg_i(bank_select_reg), .fsr2_i(fsr2),
    .file_rdata_i(frd), .pmem_rdata_i(pmd), .qphase_o(q), .busy_o(busy), .file_addr_o(fadr),
    .file_we_o(fwe), .file_wdata_o(fwd), .w_we_o(wwe), .w_wdata_o(wwd), .flush_o(flush),
    .pmem_re_o(pre), .table_pointer_o(tp), .table_latch_o(lat), .watchdog_clr_o(wclr),
    .timeout_flag_o(tof), .powerdown_flag_o(pdf), .osc_stop_o(ostop));
  // Program memory image follows the pointer
  assign pmd = tp[7:0] ^ 8'h5a;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input bit ok, input string m);
    cmp_count++;
    if (!ok) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // Present one instruction at the next accepting edge
  task issue(input logic [15:0] w, input logic tw);
    @(negedge clk);
    while (!(q === 2'h0 && busy === 1'b0)) @(negedge clk);
    vld = 1'b1; instr = w; two = tw;
    @(negedge clk);
    vld = 1'b0;
  endtask
  task do_reset;
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    chk(q === 2'h0 && busy === 1'b0 && tp === SIE_TP_RST && lat === SIE_BYTE_RST, "reset");
    chk(tof === 1'b1 && pdf === 1'b1 && ostop === 1'b0, "reset flags");
  endtask
  task t_incr;
    logic [7:0] f; logic [11:0] ea; logic sk, d; int n;
    for (int i = 0; i < 8; i++) begin
      f = i[1] ? 8'h90 : 8'h20; frd = (i[0] ^ i[1]) ? 8'hff : 8'h05;
      d = i[2] ^ i[1]; ext = i[2]; bank_select_reg = 4'h3; fsr2 = 8'h11;
      ea = (i[0] & i[1]) ? {bank_select_reg, f} : (ext && f <= SIE_IDX_LIMIT) ? {4'h0, fsr2 + f}
         : {f[7] ? 4'hf : 4'h0, f};
      sk = (frd == 8'hff) ^ i[0];
      issue({i[0] ? SIE_OP_INSNZ : SIE_OP_INCSZ, d, i[0] & i[1], f}, i[2]);
      chk(fadr === ea, "file address");
      repeat (3) @(posedge clk);
      #1;
      chk(fwe === d && wwe === !d && (d ? fwd : wwd) === frd + 8'h1, "write");
      chk(flush === sk, "flush");
      n = 0;
      repeat (12) begin
        @(negedge clk);
        n += int'(busy === 1'b1);
      end
      chk(n == (sk ? (i[2] ? 8 : 4) : 0), "skip cycles");
    end
    $display("increment-skip test done");
  endtask
  task t_tbl;
    logic [SIE_TP_W-1:0] e; logic [1:0] m;
    e = tp;
    for (int k = 0; k < 4; k++) begin
      m = 2'(3 - k);
      if (m == SIE_TM_PREINC) e = e + 1'b1;
      issue({SIE_OP_TABLE_READ_OP, m}, 1'b0);
      repeat (3) @(posedge clk);
      #1;
      chk(busy === 1'b1 && pre === 1'b1, "second cycle");
      repeat (4) @(posedge clk);
      #1;
      chk(lat === (e[7:0] ^ 8'h5a), "latch");
      if (m == SIE_TM_POSTINC) e = e + 1'b1;
      if (m == SIE_TM_POSTDEC) e = e - 1'b1;
      chk(tp === e, "pointer");
    end
    $display("table read test done");
  endtask
  task t_sleep;
    issue(SIE_OP_SLEEP, 1'b0);
    repeat (3) @(posedge clk);
    #1;
    chk(wclr === 1'b1 && tof === 1'b1 && pdf === 1'b0 && ostop === 1'b1, "sleep");
    repeat (8) @(negedge clk);
    chk(busy === 1'b1 && wclr === 1'b0, "asleep");
    $display("low-power test done");
  endtask
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence and watchdog
  initial begin
    vld = 1'b0; instr = 16'h0000; two = 1'b0; ext = 1'b0; bank_select_reg = 4'h0; fsr2 = 8'h00;
    frd = 8'h00; error_cnt = 0; cmp_count = 0;
    do_reset;
    t_incr;
    t_tbl;
    t_sleep;
    do_reset;
    end_sim;
  end
  initial begin
    #100000;
    error_cnt++;
    end_sim;
  end
endmodule
bind siexec_core siexec_properties u_props (.*);
`default_nettype wire
